// ==== core/lbe_evaluator.sv ====
// Ladder boolean rung evaluator with image register and word memory.
`include "lbe_params.svh"
`default_nettype none
// Operation
// - Rung-start contact pushes the point state, or its complement, as a new level.
// - Stack holds eight levels; a ninth push raises the error flag.
// - Parallel contact ORs top of stack with the addressed point.
// - Inverted parallel contact ORs top with the complemented point.
// - Parallel bit contact ORs top with word bit 0..15, word or pointer.
// - Inverted parallel bit contact ORs top with the complemented word bit.
// - Series contact ANDs top of stack with the addressed point.
// - Inverted series contact ANDs top with the complemented point.
// - Series bit contact ANDs top with word bit 0..15.
// - Inverted series bit contact ANDs top with complemented word bit.
// - Series merge pops two levels, ANDs them, leaves result on top.
// - Parallel merge pops two levels, ORs them, leaves result on top.
// - Coil write copies the rung state into the addressed point.
// - Repeated coil writes to one point: the last one wins.
// - Bit coil write sets one word bit, other bits unchanged.
// - Wired-OR coil ORs the rung state into the target within a scan.
// - Invert complements the rung state before later contacts or coils.
// - One-shot drives its target on for one scan on an off-to-on edge.
module lbe_evaluator
    import lbe_pkg::*;
#(
    parameter int IMG_BITS = `LBE_IMG_BITS,
    parameter int MEM_WORDS = `LBE_MEM_WORDS,
    parameter int OS_COUNT = `LBE_OS_COUNT,
    parameter int DEPTH = `LBE_STACK_DEPTH,
    parameter int WW = `LBE_WORD_W,
    parameter int IW = $clog2(IMG_BITS),
    parameter int MW = $clog2(MEM_WORDS),
    parameter int OW = $clog2(OS_COUNT),
    parameter int DW = $clog2(DEPTH + 1)
) (
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic SCAN_START_I,
    input wire logic INSTR_VALID_I,
    input wire logic [`LBE_OP_W-1:0] INSTR_OP_I,
    input wire logic [IW-1:0] INSTR_ADDR_I,
    input wire logic [MW-1:0] INSTR_WORD_I,
    input wire logic [`LBE_BIT_IDX_W-1:0] INSTR_BIT_I,
    input wire logic INSTR_PTR_I,
    input wire logic [OW-1:0] INSTR_OS_I,
    input wire logic IMG_WR_I,
    input wire logic [IW-1:0] IMG_WR_ADDR_I,
    input wire logic IMG_WR_DATA_I,
    input wire logic [IW-1:0] IMG_RD_ADDR_I,
    output logic IMG_RD_DATA_O,
    input wire logic MEM_WR_I,
    input wire logic [MW-1:0] MEM_WR_ADDR_I,
    input wire logic [WW-1:0] MEM_WR_DATA_I,
    input wire logic [MW-1:0] MEM_RD_ADDR_I,
    output logic [WW-1:0] MEM_RD_DATA_O,
    output logic RUNG_O,
    output logic [DW-1:0] DEPTH_O,
    output logic ERROR_O
);
    ////////////////////////////////////////////////////////////////////////
    logic [IMG_BITS-1:0] image;
    logic [IMG_BITS-1:0] next_image;
    logic [MEM_WORDS-1:0][WW-1:0] mem;
    logic [MEM_WORDS-1:0][WW-1:0] next_mem;
    logic [IMG_BITS-1:0] or_seen;
    logic [IMG_BITS-1:0] next_or_seen;
    logic [OS_COUNT-1:0] os_prev;
    logic [OS_COUNT-1:0] next_os_prev;
    logic rung_done;
    logic next_rung_done;
    logic img_rd;
    logic next_img_rd;
    logic [WW-1:0] mem_rd;
    logic [WW-1:0] next_mem_rd;
    lbe_op_e op;
    logic top;
    logic second;
    logic pt;
    logic wb;
    logic [MW-1:0] eff_word;
    logic push;
    logic replace;
    logic merge;
    logic val;

    assign op = lbe_op_e'(INSTR_OP_I);
    assign pt = image[INSTR_ADDR_I];
    // A pointer operand takes the word address from the low bits of a word.
    assign eff_word = INSTR_PTR_I ? mem[INSTR_WORD_I][MW-1:0] : INSTR_WORD_I;
    assign wb = mem[eff_word][INSTR_BIT_I];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        push = 1'b0;
        replace = 1'b0;
        merge = 1'b0;
        val = 1'b0;
        next_image = image;
        next_mem = mem;
        next_os_prev = os_prev;
        next_or_seen = SCAN_START_I ? '0 : or_seen;
        next_rung_done = SCAN_START_I | rung_done;
        next_img_rd = image[IMG_RD_ADDR_I];
        next_mem_rd = mem[MEM_RD_ADDR_I];
        if (INSTR_VALID_I) begin
            unique case (op)
                LBE_RUNG_START_CONTACT: begin
                    push = 1'b1;
                    val = pt;
                end
                LBE_RUNG_START_INVERTED_CONTACT: begin
                    push = 1'b1;
                    val = ~pt;
                end
                LBE_RUNG_START_BIT_CONTACT: begin
                    push = 1'b1;
                    val = wb;
                end
                LBE_RUNG_START_INVERTED_BIT_CONTACT: begin
                    push = 1'b1;
                    val = ~wb;
                end
                LBE_PARALLEL_CONTACT: begin
                    replace = 1'b1;
                    val = top | pt;
                end
                LBE_PARALLEL_INVERTED_CONTACT: begin
                    replace = 1'b1;
                    val = top | ~pt;
                end
                LBE_PARALLEL_BIT_CONTACT: begin
                    replace = 1'b1;
                    val = top | wb;
                end
                LBE_PARALLEL_INVERTED_BIT_CONTACT: begin
                    replace = 1'b1;
                    val = top | ~wb;
                end
                LBE_SERIES_CONTACT: begin
                    replace = 1'b1;
                    val = top & pt;
                end
                LBE_SERIES_INVERTED_CONTACT: begin
                    replace = 1'b1;
                    val = top & ~pt;
                end
                LBE_SERIES_BIT_CONTACT: begin
                    replace = 1'b1;
                    val = top & wb;
                end
                LBE_SERIES_INVERTED_BIT_CONTACT: begin
                    replace = 1'b1;
                    val = top & ~wb;
                end
                LBE_SERIES_BRANCH_MERGE: begin
                    merge = 1'b1;
                    val = top & second;
                end
                LBE_PARALLEL_BRANCH_MERGE: begin
                    merge = 1'b1;
                    val = top | second;
                end
                LBE_COIL_WRITE: begin
                    // Written in program order, so a later write overrides.
                    next_image[INSTR_ADDR_I] = top;
                    next_rung_done = 1'b1;
                end
                LBE_BIT_COIL_WRITE: begin
                    next_mem[eff_word][INSTR_BIT_I] = top;
                    next_rung_done = 1'b1;
                end
                LBE_WIRED_OR_COIL: begin
                    // The first write of a scan loads, later ones accumulate.
                    next_image[INSTR_ADDR_I] =
                        (next_or_seen[INSTR_ADDR_I] & pt) | top;
                    next_or_seen[INSTR_ADDR_I] = 1'b1;
                    next_rung_done = 1'b1;
                end
                LBE_INVERT: begin
                    replace = 1'b1;
                    val = ~top;
                end
                LBE_RISING_EDGE_ONE_SHOT: begin
                    next_image[INSTR_ADDR_I] = top & ~os_prev[INSTR_OS_I];
                    next_os_prev[INSTR_OS_I] = top;
                    next_rung_done = 1'b1;
                end
                LBE_NOP: begin
                end
                default: begin
                end
            endcase
            if (push) begin
                next_rung_done = 1'b0;
            end
        end else begin
            // Outside writes are refused while an instruction executes.
            if (IMG_WR_I) begin
                next_image[IMG_WR_ADDR_I] = IMG_WR_DATA_I;
            end
            if (MEM_WR_I) begin
                next_mem[MEM_WR_ADDR_I] = MEM_WR_DATA_I;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            image <= '0;
            mem <= '0;
            or_seen <= '0;
            os_prev <= '0;
            rung_done <= 1'b1;
            img_rd <= 1'b0;
            mem_rd <= '0;
        end else begin
            image <= next_image;
            mem <= next_mem;
            or_seen <= next_or_seen;
            os_prev <= next_os_prev;
            rung_done <= next_rung_done;
            img_rd <= next_img_rd;
            mem_rd <= next_mem_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // A rung start after a coil discards the finished rung's levels.
    lbe_stack #(
        .DEPTH(DEPTH),
        .DW(DW)
    ) u_stack (
        .clk_i(MCLK_I),
        .arst_n_i(ARST_N_I),
        .clear_i(SCAN_START_I | (push & rung_done)),
        .push_i(push),
        .replace_i(replace),
        .merge_i(merge),
        .val_i(val),
        .top_o(top),
        .second_o(second),
        .depth_o(DEPTH_O),
        .err_o(ERROR_O)
    );

    assign RUNG_O = top;
    assign IMG_RD_DATA_O = img_rd;
    assign MEM_RD_DATA_O = mem_rd;

    ////////////////////////////////////////////////////////////////////////
    logic v;
    logic deep;
    logic [WW-1:0] bit_mask;
    assign v = INSTR_VALID_I & ~SCAN_START_I;
    assign deep = ~rung_done & (DEPTH_O != '0);
    assign bit_mask = WW'(1) << INSTR_BIT_I;

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    AST_START_PUSH: assert property (
        v && op == LBE_RUNG_START_INVERTED_CONTACT && rung_done
        |=> RUNG_O == !$past(pt) && DEPTH_O == DW'(1))
        else $error("rung start did not push inverted point");
    AST_OVERFLOW: assert property (
        v && op == LBE_RUNG_START_CONTACT && !rung_done
        && DEPTH_O == DW'(DEPTH)
        |=> ERROR_O && DEPTH_O == DW'(DEPTH))
        else $error("ninth level did not raise error");
    AST_OR: assert property (
        v && op == LBE_PARALLEL_CONTACT && deep
        |=> RUNG_O == ($past(top) | $past(pt)))
        else $error("parallel contact result wrong");
    AST_ORN_BIT: assert property (
        v && op == LBE_PARALLEL_INVERTED_BIT_CONTACT && deep
        |=> RUNG_O == ($past(top) | !$past(wb)))
        else $error("inverted parallel bit contact wrong");
    AST_AND_BIT: assert property (
        v && op == LBE_SERIES_BIT_CONTACT && deep
        |=> RUNG_O == ($past(top) & $past(wb))
        && DEPTH_O == $past(DEPTH_O))
        else $error("series bit contact wrong");
    AST_SERIES_INVERTED_CONTACT: assert property (
        v && op == LBE_SERIES_INVERTED_CONTACT && deep
        |=> RUNG_O == ($past(top) & !$past(pt)))
        else $error("inverted series contact wrong");
    AST_MERGE: assert property (
        v && op == LBE_SERIES_BRANCH_MERGE && DEPTH_O > DW'(1)
        |=> RUNG_O == ($past(top) & $past(second))
        && DEPTH_O == $past(DEPTH_O) - DW'(1))
        else $error("series merge wrong");
    AST_COIL: assert property (
        v && op == LBE_COIL_WRITE
        |=> image[$past(INSTR_ADDR_I)] == $past(top))
        else $error("coil did not copy rung state");
    AST_BIT_COIL: assert property (
        v && op == LBE_BIT_COIL_WRITE
        |=> mem[$past(eff_word)] == (($past(mem[eff_word]) & ~$past(bit_mask))
        | ({WW{$past(top)}} & $past(bit_mask))))
        else $error("bit coil disturbed other bits");
    AST_WIRED_OR: assert property (
        v && op == LBE_WIRED_OR_COIL && top
        ##1 v && op == LBE_WIRED_OR_COIL
        && INSTR_ADDR_I == $past(INSTR_ADDR_I)
        |=> image[$past(INSTR_ADDR_I)])
        else $error("wired or coil lost an on rung");
    AST_ONE_SHOT: assert property (
        v && op == LBE_RISING_EDGE_ONE_SHOT
        |=> image[$past(INSTR_ADDR_I)]
        == ($past(top) && !$past(os_prev[INSTR_OS_I]))
        && os_prev[$past(INSTR_OS_I)] == $past(top))
        else $error("one shot output wrong");
    AST_INVERT: assert property (
        v && op == LBE_INVERT && deep |=> RUNG_O == !$past(top))
        else $error("invert did not complement");

    COV_OVERFLOW: cover property (ERROR_O && !$past(ERROR_O));
    COV_MERGE: cover property (
        v && op == LBE_PARALLEL_BRANCH_MERGE && DEPTH_O > DW'(1));
    COV_ONE_SHOT: cover property (
        v && op == LBE_RISING_EDGE_ONE_SHOT && top && !os_prev[INSTR_OS_I]);
endmodule : lbe_evaluator
`default_nettype wire

// ==== core/lbe_params.svh ====
// Constants of the ladder boolean evaluator.
`ifndef LBE_PARAMS_SVH
`define LBE_PARAMS_SVH
`define LBE_STACK_DEPTH 8
`define LBE_BIT_IDX_W 4
`define LBE_WORD_W 16
`define LBE_IMG_BITS 256
`define LBE_MEM_WORDS 64
`define LBE_OS_COUNT 16
`define LBE_OP_W 5
`endif

// ==== core/lbe_pkg.sv ====
// Types of the ladder boolean evaluator.
`default_nettype none
package lbe_pkg;
    typedef enum logic [4:0] {
        LBE_NOP,
        LBE_RUNG_START_CONTACT,
        LBE_RUNG_START_INVERTED_CONTACT,
        LBE_RUNG_START_BIT_CONTACT,
        LBE_RUNG_START_INVERTED_BIT_CONTACT,
        LBE_PARALLEL_CONTACT,
        LBE_PARALLEL_INVERTED_CONTACT,
        LBE_PARALLEL_BIT_CONTACT,
        LBE_PARALLEL_INVERTED_BIT_CONTACT,
        LBE_SERIES_CONTACT,
        LBE_SERIES_INVERTED_CONTACT,
        LBE_SERIES_BIT_CONTACT,
        LBE_SERIES_INVERTED_BIT_CONTACT,
        LBE_SERIES_BRANCH_MERGE,
        LBE_PARALLEL_BRANCH_MERGE,
        LBE_COIL_WRITE,
        LBE_BIT_COIL_WRITE,
        LBE_WIRED_OR_COIL,
        LBE_INVERT,
        LBE_RISING_EDGE_ONE_SHOT
    } lbe_op_e;
endpackage : lbe_pkg
`default_nettype wire

// ==== core/lbe_stack.sv ====
// Evaluation stack of rung states, entry 0 is the top.
`include "lbe_params.svh"
`default_nettype none
module lbe_stack
    import lbe_pkg::*;
#(
    parameter int DEPTH = `LBE_STACK_DEPTH,
    parameter int DW = $clog2(DEPTH + 1)
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic clear_i,
    input wire logic push_i,
    input wire logic replace_i,
    input wire logic merge_i,
    input wire logic val_i,
    output logic top_o,
    output logic second_o,
    output logic [DW-1:0] depth_o,
    output logic err_o
);
    logic [DEPTH-1:0] stk;
    logic [DEPTH-1:0] next_stk;
    logic [DW-1:0] depth;
    logic [DW-1:0] next_depth;
    logic [DW-1:0] base;
    logic err;
    logic next_err;
    logic fault;

    always_comb begin
        next_stk = stk;
        base = clear_i ? '0 : depth;
        next_depth = base;
        fault = 1'b0;
        if (push_i) begin
            if (base == DW'(DEPTH)) begin
                // A ninth level is refused and the stack is left as it was.
                fault = 1'b1;
            end else begin
                for (int i = DEPTH - 1; i > 0; i--) begin
                    next_stk[i] = stk[i-1];
                end
                next_stk[0] = val_i;
                next_depth = base + DW'(1);
            end
        end else if (replace_i) begin
            fault = (base == '0);
            next_stk[0] = val_i;
        end else if (merge_i) begin
            if (base < DW'(2)) begin
                fault = 1'b1;
            end else begin
                for (int i = 1; i < DEPTH - 1; i++) begin
                    next_stk[i] = stk[i+1];
                end
                next_stk[DEPTH-1] = 1'b0;
                next_stk[0] = val_i;
                next_depth = base - DW'(1);
            end
        end
        // A fault in the clearing cycle survives the clear.
        next_err = (err & ~clear_i) | fault;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stk <= '0;
            depth <= '0;
            err <= 1'b0;
        end else begin
            stk <= next_stk;
            depth <= next_depth;
            err <= next_err;
        end
    end

    assign top_o = stk[0];
    assign second_o = stk[1];
    assign depth_o = depth;
    assign err_o = err;
endmodule : lbe_stack
`default_nettype wire

// ==== verif/lbe_evaluator_tb.sv ====
// Self-checking testbench of the ladder boolean evaluator.
`default_nettype none
module lbe_evaluator_tb
    import lbe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        int due;
        int kind;
        logic [15:0] val;
    } lbe_tb_note_s;

    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic scan_start = 1'b0;
    logic valid = 1'b0;
    logic [4:0] op = 5'h00;
    logic [7:0] addr = 8'h00;
    logic [5:0] word = 6'h00;
    logic [3:0] bit_idx = 4'h0;
    logic ptr = 1'b0;
    logic [3:0] os = 4'h0;
    logic img_wr = 1'b0;
    logic [7:0] img_wr_addr = 8'h00;
    logic img_wr_data = 1'b0;
    logic [7:0] img_rd_addr = 8'h00;
    logic img_rd_data;
    logic mem_wr = 1'b0;
    logic [5:0] mem_wr_addr = 6'h00;
    logic [15:0] mem_wr_data = 16'h0000;
    logic [5:0] mem_rd_addr = 6'h00;
    logic [15:0] mem_rd_data;
    logic rung;
    logic [3:0] depth;
    logic err;
    int cyc = 0;
    int fails = 0;
    int checks_done = 0;
    logic img_m [0:31];
    logic [15:0] w;
    lbe_tb_note_s notes [$];

    always #5 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    lbe_evaluator dut (
        .MCLK_I(mclk), .ARST_N_I(arst_n), .SCAN_START_I(scan_start),
        .INSTR_VALID_I(valid), .INSTR_OP_I(op), .INSTR_ADDR_I(addr),
        .INSTR_WORD_I(word), .INSTR_BIT_I(bit_idx), .INSTR_PTR_I(ptr),
        .INSTR_OS_I(os), .IMG_WR_I(img_wr), .IMG_WR_ADDR_I(img_wr_addr),
        .IMG_WR_DATA_I(img_wr_data), .IMG_RD_ADDR_I(img_rd_addr),
        .IMG_RD_DATA_O(img_rd_data), .MEM_WR_I(mem_wr),
        .MEM_WR_ADDR_I(mem_wr_addr), .MEM_WR_DATA_I(mem_wr_data),
        .MEM_RD_ADDR_I(mem_rd_addr), .MEM_RD_DATA_O(mem_rd_data),
        .RUNG_O(rung), .DEPTH_O(depth), .ERROR_O(err)
    );

    ////////////////////////////////////////////////////////////////////////
    // Every result shows two counts after the edge at which it was noted.
    task automatic want(input int k, input logic [15:0] v);
        lbe_tb_note_s n;
        n.due = cyc + 2;
        n.kind = k;
        n.val = v;
        notes.push_back(n);
    endtask : want

    task automatic stat(input logic r, input logic [3:0] d, input logic e);
        want(0, {10'h000, e, d, r});
    endtask : stat

    task automatic op_go(input logic [4:0] o, input logic sc,
                         input logic [7:0] a);
        @(posedge mclk);
        scan_start <= sc;
        valid <= 1'b1;
        op <= o;
        addr <= a;
    endtask : op_go

    // Valid is dropped so that a held instruction is not executed twice.
    task automatic rd(input int k, input logic [7:0] a,
                      input logic [15:0] v);
        @(posedge mclk);
        valid <= 1'b0;
        scan_start <= 1'b0;
        img_rd_addr <= a;
        mem_rd_addr <= a[5:0];
        want(k, v);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [15:0] v,
                      input logic m);
        @(posedge mclk);
        valid <= 1'b0;
        img_wr <= !m;
        mem_wr <= m;
        img_wr_addr <= a;
        img_wr_data <= v[0];
        mem_wr_addr <= a[5:0];
        mem_wr_data <= v;
        @(posedge mclk);
        img_wr <= 1'b0;
        mem_wr <= 1'b0;
    endtask : wr

    function automatic logic comb(input int k, input logic x, input logic v);
        case (k)
            5, 7: return x | v;
            6, 8: return x | ~v;
            9, 11: return x & v;
            default: return x & ~v;
        endcase
    endfunction : comb

    task automatic close_out;
        if (notes.size() > 0) fails++;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////
    always @(negedge mclk) begin
        lbe_tb_note_s n;
        logic [15:0] got;
        if (notes.size() > 0 && notes[0].due == cyc) begin
            n = notes.pop_front();
            got = n.kind == 0 ? {10'h000, err, depth, rung} :
                  n.kind == 1 ? {15'h0000, img_rd_data} : mem_rd_data;
            checks_done++;
            if (got !== n.val) begin
                fails++;
                $display("[FAIL] %0t: kind %0d got %h expected %h",
                         $time, n.kind, got, n.val);
            end
        end
    end

    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        $display("[FAIL] %0t: watchdog expired", $time);
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int s;
        logic x;
        logic v;
        logic prev;
        logic [4:0] pat;
        s = $urandom(32'hd0f2);
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            img_m[i] = i == 31 ? 1'b1 : i == 30 ? 1'b0 : 1'($urandom());
            wr(8'(i), {15'h0000, img_m[i]}, 1'b0);
        end
        w = 16'($urandom());
        wr(8'h03, w, 1'b1);
        wr(8'h05, 16'h0003, 1'b1);
        // Odd passes open with the inverted start, pointer use alternates every two passes.
        for (int k = 5; k <= 12; k++) begin
            for (int b = 0; b < 16; b++) begin
                x = b[0] ? ~img_m[b + 1] : img_m[b + 1];
                op_go(b[0] ? LBE_RUNG_START_INVERTED_CONTACT :
                      LBE_RUNG_START_CONTACT, 1'b1, 8'(b + 1));
                op_go(5'(k), 1'b0, 8'(b));
                word <= b[1] ? 6'h05 : 6'h03;
                ptr <= b[1];
                bit_idx <= 4'(b);
                v = k inside {7, 8, 11, 12} ? w[b] : img_m[b];
                stat(comb(k, x, v), 4'h1, 1'b0);
            end
        end
        $display("test contacts done");
        for (int k = 13; k <= 14; k++) begin
            op_go(LBE_RUNG_START_CONTACT, 1'b1, 8'h01);
            op_go(LBE_RUNG_START_CONTACT, 1'b0, 8'h02);
            stat(img_m[2], 4'h2, 1'b0);
            op_go(LBE_SERIES_CONTACT, 1'b0, 8'h03);
            op_go(5'(k), 1'b0, 8'h00);
            x = img_m[2] & img_m[3];
            stat(k == 13 ? img_m[1] & x : img_m[1] | x, 4'h1, 1'b0);
        end
        for (int i = 0; i < 9; i++) begin
            op_go(LBE_RUNG_START_CONTACT, i == 0, i == 8 ? 8'h1e : 8'h1f);
            if (i >= 7) stat(1'b1, 4'h8, i == 8);
        end
        op_go(LBE_RUNG_START_CONTACT, 1'b1, 8'h1f);
        op_go(LBE_PARALLEL_BRANCH_MERGE, 1'b0, 8'h00);
        stat(1'b1, 4'h1, 1'b1);
        op_go(LBE_RUNG_START_CONTACT, 1'b1, 8'h1f);
        stat(1'b1, 4'h1, 1'b0);
        $display("test stack done");
        op_go(LBE_RUNG_START_CONTACT, 1'b1, 8'h01);
        op_go(LBE_COIL_WRITE, 1'b0, 8'h14);
        op_go(LBE_RUNG_START_INVERTED_CONTACT, 1'b0, 8'h01);
        op_go(LBE_COIL_WRITE, 1'b0, 8'h14);
        rd(1, 8'h14, {15'h0000, ~img_m[1]});
        // The coil has overwritten point 20, so the mirror must follow it.
        img_m[20] = ~img_m[1];
        for (int b = 0; b < 16; b++) begin
            op_go(LBE_RUNG_START_CONTACT, 1'b1, 8'(b + 8));
            op_go(LBE_BIT_COIL_WRITE, 1'b0, 8'h00);
            word <= 6'h03;
            ptr <= 1'b0;
            bit_idx <= 4'(b);
            w[b] = img_m[b + 8];
            rd(2, 8'h03, w);
        end
        op_go(LBE_RUNG_START_CONTACT, 1'b1, 8'h1e);
        op_go(LBE_WIRED_OR_COIL, 1'b0, 8'h15);
        op_go(LBE_RUNG_START_CONTACT, 1'b0, 8'h1f);
        op_go(LBE_WIRED_OR_COIL, 1'b0, 8'h15);
        op_go(LBE_WIRED_OR_COIL, 1'b0, 8'h15);
        rd(1, 8'h15, 16'h0001);
        op_go(LBE_RUNG_START_CONTACT, 1'b1, 8'h1e);
        op_go(LBE_WIRED_OR_COIL, 1'b0, 8'h15);
        rd(1, 8'h15, 16'h0000);
        $display("test coils done");
        op_go(LBE_RUNG_START_CONTACT, 1'b1, 8'h1f);
        op_go(LBE_INVERT, 1'b0, 8'h00);
        stat(1'b0, 4'h1, 1'b0);
        op_go(LBE_PARALLEL_CONTACT, 1'b0, 8'h1f);
        stat(1'b1, 4'h1, 1'b0);
        // Word 5 holds 3, so bit 0 is on for the plain and inverted starts.
        op_go(LBE_RUNG_START_BIT_CONTACT, 1'b1, 8'h00);
        word <= 6'h05;
        ptr <= 1'b0;
        bit_idx <= 4'h0;
        stat(1'b1, 4'h1, 1'b0);
        op_go(LBE_RUNG_START_INVERTED_BIT_CONTACT, 1'b0, 8'h00);
        stat(1'b0, 4'h2, 1'b0);
        prev = 1'b0;
        pat = 5'b10110;
        os <= 4'h2;
        for (int i = 0; i < 5; i++) begin
            op_go(LBE_RUNG_START_CONTACT, 1'b1, pat[i] ? 8'h1f : 8'h1e);
            op_go(LBE_RISING_EDGE_ONE_SHOT, 1'b0, 8'h16);
            rd(1, 8'h16, {15'h0000, pat[i] & ~prev});
            prev = pat[i];
        end
        $display("test invert and one-shot done");
        repeat (4) @(posedge mclk);
        close_out();
    end
endmodule : lbe_evaluator_tb
`default_nettype wire
